// file: bus_trace_capture.sv
// Purpose: samples target bus cycles and probes into a circular trace memory
// Assumes: all target pins asynchronous to ref_clk_in, bus clock well below 20 MHz
// Notes: perf stop inputs come from logic on ref_clk_in
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module bus_trace_capture (
   // clock and reset
   input  wire logic                         ref_clk_in,
   input  wire logic                         sys_rst_in,
   // target pins
   input  wire logic                         target_bus_clock_in,
   input  wire logic                         second_bus_state_in,
   input  wire logic                         bus_cycle_end_in,
   input  wire trace_pkg::bus_pins_s         bus_pins_in,
   input  wire logic [3:0]                   probe_inputs_in,
   // performance analysis and trigger
   input  wire logic                         perf_time_over_in,
   input  wire logic                         perf_count_over_in,
   input  wire logic                         delay_met_in,
   // register port
   input  wire logic [trace_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [31:0]                  reg_wdata_in,
   input  wire logic                         reg_wr_in,
   input  wire logic                         reg_rd_in,
   output logic [31:0]                       reg_rdata_out,
   // status
   output logic                              irq_out,
   output logic                              running_out
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   // first stage feeds only the second; sampled fields may straddle a change
   trace_pkg::bus_pins_s  bus_s1_reg, bus_s2_reg;
   logic [3:0]            prb_s1_reg, prb_s2_reg;
   logic [2:0]            ctl_s1_reg, ctl_s2_reg;
   logic                  bclk_d_reg;
   always_ff @(posedge ref_clk_in) begin
      bus_s1_reg <= bus_pins_in;
      bus_s2_reg <= bus_s1_reg;
      prb_s1_reg <= probe_inputs_in;
      prb_s2_reg <= prb_s1_reg;
      ctl_s1_reg <= {bus_cycle_end_in, second_bus_state_in, target_bus_clock_in};
      ctl_s2_reg <= ctl_s1_reg;
      bclk_d_reg <= ctl_s2_reg[0];
   end
   logic rise, fall, in_t2, cyc_end;
   assign rise    = ctl_s2_reg[0] & ~bclk_d_reg;
   assign fall    = ~ctl_s2_reg[0] & bclk_d_reg;
   assign in_t2   = ctl_s2_reg[1];
   assign cyc_end = rise & ctl_s2_reg[2];

   // ****************************************
   // registers
   // ****************************************
   trace_pkg::ctrl_s       ctrl_reg;
   logic [2:0]             istat_reg, imask_reg, ev;
   logic [trace_pkg::PTR_W-1:0] ridx_reg, wptr_reg;
   logic                   stopped_reg, ovf_stop_reg, tmo_stop_reg;
   logic                   clr_istat, start_wr;
   assign clr_istat = reg_rd_in & (reg_addr_in == trace_pkg::REG_ISTAT);
   assign start_wr  = reg_wr_in & (reg_addr_in == trace_pkg::REG_CTRL) & reg_wdata_in[$bits(trace_pkg::ctrl_s)-1];
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ctrl_reg  <= trace_pkg::CTRL_RST;   // TS_20NS stamp mode by default, one 25 ns clock per stamp step
         imask_reg <= 3'h0;
         ridx_reg  <= '0;
      end else if (reg_wr_in) begin
         if (reg_addr_in == trace_pkg::REG_CTRL) begin
            ctrl_reg       <= trace_pkg::ctrl_s'(reg_wdata_in[$bits(trace_pkg::ctrl_s)-1:0]);
            ctrl_reg.start <= 1'b0;
         end
         if (reg_addr_in == trace_pkg::REG_IMASK) begin
            imask_reg <= reg_wdata_in[2:0];
         end
         if (reg_addr_in == trace_pkg::REG_RIDX) begin
            ridx_reg <= reg_wdata_in[trace_pkg::PTR_W-1:0];
         end
      end
   end
   // a new event beats the read that clears it
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         istat_reg <= 3'h0;
      end else begin
         istat_reg <= (clr_istat ? 3'h0 : istat_reg) | ev;
      end
   end
   assign irq_out = |(istat_reg & imask_reg);

   // ****************************************
   // sampling within a bus cycle
   // ****************************************
   trace_pkg::bus_pins_s bus_cap_reg;
   logic [3:0]           prb_cap_reg;
   logic                 prb_taken_reg;
   logic [1:0]           smp_cnt_reg;
   logic [7:0]           cyc_cnt_reg;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | cyc_end) begin
         smp_cnt_reg <= 2'h0;
      end else if (rise & in_t2 & (smp_cnt_reg < 2'(trace_pkg::MAX_SMP))) begin
         smp_cnt_reg <= smp_cnt_reg + 2'h1;   // later wait-state edges ignored
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         bus_cap_reg <= '0;
      end else if (rise & in_t2 & (smp_cnt_reg < 2'(trace_pkg::MAX_SMP))) begin
         bus_cap_reg <= bus_s2_reg;
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | cyc_end) begin
         prb_taken_reg <= 1'b0;
      end else if (fall & in_t2 & ~prb_taken_reg) begin
         prb_taken_reg <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         prb_cap_reg <= 4'h0;
      end else if (fall & in_t2 & ~prb_taken_reg) begin
         prb_cap_reg <= prb_s2_reg;   // one sample per cycle, later changes dropped
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | cyc_end) begin
         cyc_cnt_reg <= 8'h0;
      end else if (rise & (cyc_cnt_reg != 8'hFF)) begin
         cyc_cnt_reg <= cyc_cnt_reg + 8'h1;
      end
   end

   // ****************************************
   // time stamp
   // ****************************************
   function automatic logic [11:0] ts_div(input trace_pkg::ts_mode_e m);
      case (m)
         trace_pkg::TS_20NS:  ts_div = 12'(trace_pkg::TS0_CYC);
         trace_pkg::TS_1US6:  ts_div = 12'(trace_pkg::TS1_CYC);
         trace_pkg::TS_52US:  ts_div = 12'(trace_pkg::TS2_CYC);
         trace_pkg::TS_BCLK2: ts_div = 12'h2;
         trace_pkg::TS_BCLK4: ts_div = 12'h4;
         trace_pkg::TS_BCLK8: ts_div = 12'h8;
         default:             ts_div = 12'h1;
      endcase
   endfunction
   logic [11:0] pre_reg;
   logic [31:0] stamp_reg;
   logic        abs_mode, tick, pre_done;
   assign abs_mode = ctrl_reg.ts_mode < trace_pkg::TS_BCLK;
   assign tick     = abs_mode | rise;   // bus modes step on target clocks
   assign pre_done = pre_reg >= ts_div(ctrl_reg.ts_mode) - 12'h1;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | start_wr) begin
         pre_reg   <= 12'h0;
         stamp_reg <= 32'h0;
      end else if (tick) begin
         pre_reg <= pre_done ? 12'h0 : pre_reg + 12'h1;
         if (pre_done) begin
            stamp_reg <= stamp_reg + 32'h1;
         end
      end
   end

   // ****************************************
   // record memory
   // ****************************************
   trace_pkg::record_s   mem [trace_pkg::DEPTH];
   trace_pkg::bus_pins_s rec_bus;
   logic [trace_pkg::SEQ_W-1:0] seq_reg, dly_seq_reg;
   logic [trace_pkg::PTR_W:0]   fill_reg;
   logic  keep, full, do_wr, ovf_hit, tmo_hit, active;
   always_comb begin
      rec_bus = bus_cap_reg;
      if (bus_cap_reg.ctype == trace_pkg::CT_DAT && bus_cap_reg.pc_rel) begin
         rec_bus.ctype = trace_pkg::CT_PRG;
      end
   end
   assign active  = ctrl_reg.run & ~stopped_reg;
   assign keep    = (smp_cnt_reg != 2'h0) & (ctrl_reg.dma_en | (bus_cap_reg.ctype != trace_pkg::CT_DMA));
   assign full    = fill_reg == (trace_pkg::PTR_W+1)'(trace_pkg::DEPTH);
   assign ovf_hit = active & cyc_end & keep & full & ctrl_reg.ovf_stop_en;
   assign tmo_hit = active & ctrl_reg.tmo_stop_en & (perf_time_over_in | perf_count_over_in);
   assign do_wr   = active & cyc_end & keep & ~ovf_hit & ~tmo_hit;
   assign ev      = {delay_met_in & active, do_wr & (&wptr_reg), ovf_hit | tmo_hit};
   assign running_out = active;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | start_wr) begin
         stopped_reg  <= 1'b0;
         ovf_stop_reg <= 1'b0;
         tmo_stop_reg <= 1'b0;
      end else begin
         if (ovf_hit) begin
            stopped_reg  <= 1'b1;
            ovf_stop_reg <= 1'b1;
         end
         if (tmo_hit) begin
            stopped_reg  <= 1'b1;
            tmo_stop_reg <= 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | start_wr) begin
         wptr_reg <= '0;
         fill_reg <= '0;
         seq_reg  <= '0;
      end else if (do_wr) begin
         wptr_reg <= wptr_reg + 1'b1;   // natural wrap of a power-of-two depth
         seq_reg  <= seq_reg + 1'b1;
         if (!full) begin
            fill_reg <= fill_reg + 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (do_wr) begin
         mem[wptr_reg] <= '{bus: rec_bus, probe: prb_cap_reg, cycles: cyc_cnt_reg + 8'h1,
                            stamp: stamp_reg, seq: seq_reg};
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | start_wr) begin
         dly_seq_reg <= '0;
      end else if (delay_met_in & active) begin
         dly_seq_reg <= seq_reg;   // record written at this point reads +0
      end
   end

   // ****************************************
   // read port
   // ****************************************
   trace_pkg::record_s rrec;
   assign rrec = mem[ridx_reg];
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in | ~reg_rd_in) begin
         reg_rdata_out <= 32'h0;
      end else begin
         case (reg_addr_in)
            trace_pkg::REG_CTRL:   reg_rdata_out <= 32'(ctrl_reg);
            trace_pkg::REG_STAT:   reg_rdata_out <= 32'({fill_reg, tmo_stop_reg, ovf_stop_reg, stopped_reg, active});
            trace_pkg::REG_ISTAT:  reg_rdata_out <= 32'(istat_reg);
            trace_pkg::REG_IMASK:  reg_rdata_out <= 32'(imask_reg);
            trace_pkg::REG_RIDX:   reg_rdata_out <= 32'({wptr_reg, ridx_reg});
            trace_pkg::REG_R_PC:   reg_rdata_out <= rrec.bus.pc;
            trace_pkg::REG_R_ADDR: reg_rdata_out <= rrec.bus.addr;
            trace_pkg::REG_R_DATA: reg_rdata_out <= rrec.bus.data;
            trace_pkg::REG_R_INFO: reg_rdata_out <= 32'({rrec.probe, rrec.bus.bus_request_input, rrec.bus.manual_reset_input, rrec.bus.res,
                                                         rrec.bus.nmi, rrec.bus.irq, rrec.bus.ctype, rrec.bus.area,
                                                         rrec.bus.write});
            trace_pkg::REG_R_CYC:  reg_rdata_out <= 32'(rrec.cycles);
            trace_pkg::REG_R_TS:   reg_rdata_out <= rrec.stamp;
            trace_pkg::REG_R_PTR:  reg_rdata_out <= 32'(signed'(rrec.seq - dly_seq_reg));
            default:               reg_rdata_out <= 32'h0;
         endcase
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   property p_tmo_stop;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      active & ctrl_reg.tmo_stop_en & perf_count_over_in & ~start_wr |=> stopped_reg & ~running_out;
   endproperty
   a_tmo_stop: assert property (p_tmo_stop) else $error("timeout did not stop trace");
   property p_ovf_stop;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      ovf_hit & ~start_wr |=> $stable(wptr_reg) & ovf_stop_reg;
   endproperty
   a_ovf_stop: assert property (p_ovf_stop) else $error("overflow stop wrote a record");
   property p_dma_skip;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      cyc_end & ~ctrl_reg.dma_en & (bus_cap_reg.ctype == trace_pkg::CT_DMA) & ~start_wr |=> $stable(wptr_reg);
   endproperty
   a_dma_skip: assert property (p_dma_skip) else $error("dma cycle recorded while disabled");
   property p_ts_default;
      @(posedge ref_clk_in) sys_rst_in |=> ctrl_reg.ts_mode == trace_pkg::TS_20NS;
   endproperty
   a_ts_default: assert property (p_ts_default) else $error("stamp unit not 20 ns after reset");
   property p_ts_bus;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      ~abs_mode & ~rise & ~start_wr |=> $stable(stamp_reg);
   endproperty
   a_ts_bus: assert property (p_ts_bus) else $error("bus stamp moved without bus clock");
   property p_cap;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      rise & in_t2 & (smp_cnt_reg == 2'h0) & ~cyc_end |=> bus_cap_reg == $past(bus_s2_reg);
   endproperty
   a_cap: assert property (p_cap) else $error("bus fields not captured at rising edge");
   property p_cycles;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      do_wr |=> mem[$past(wptr_reg)].cycles == $past(cyc_cnt_reg) + 8'h1;
   endproperty
   a_cycles: assert property (p_cycles) else $error("cycle count not stored");
   property p_prb_hold;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      prb_taken_reg & ~cyc_end |=> $stable(prb_cap_reg);
   endproperty
   a_prb_hold: assert property (p_prb_hold) else $error("probe record changed after sampling");
   property p_prb_fall;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      fall & in_t2 & ~prb_taken_reg & ~cyc_end |=> prb_cap_reg == $past(prb_s2_reg);
   endproperty
   a_prb_fall: assert property (p_prb_fall) else $error("probe not taken at falling edge");
   property p_max_smp;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      rise & in_t2 & (smp_cnt_reg == 2'(trace_pkg::MAX_SMP)) & ~cyc_end |=> $stable(bus_cap_reg);
   endproperty
   a_max_smp: assert property (p_max_smp) else $error("more than three samples in a cycle");
   property p_dly;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      delay_met_in & active & ~start_wr |=> dly_seq_reg == $past(seq_reg);
   endproperty
   a_dly: assert property (p_dly) else $error("delay point not latched");
   property p_wrap;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      do_wr & (&wptr_reg) & ~start_wr |=> wptr_reg == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");
   c_wrap:  cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) do_wr & (&wptr_reg));
   c_ovf:   cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) ovf_hit);
   c_tmo:   cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) tmo_hit);
   c_three: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) rise & in_t2 & (smp_cnt_reg == 2'h3));
endmodule

// file: target_bus_model.sv
// Purpose: behavioural target bus and probe driver for the trace capture block
// Assumes: bus clock half period 100 ns, so every level lasts several reference clocks
// Notes: bus clock stands low between cycles; released bus pins show the inverse value
`timescale 1ns/1ps
module target_bus_model (
   // target pins
   output logic                 target_bus_clock_out,
   output logic                 second_bus_state_out,
   output logic                 bus_cycle_end_out,
   output trace_pkg::bus_pins_s bus_pins_out,
   output logic [3:0]           probe_inputs_out
);
   initial begin
      target_bus_clock_out = 1'b0;
      second_bus_state_out = 1'b0;
      bus_cycle_end_out = 1'b0;
      bus_pins_out = '1;
      probe_inputs_out = 4'h0;
   end
   // ****************************************
   // one bus cycle of n bus clocks, second state in the clock before the end
   // ****************************************
   task automatic cycle(input trace_pkg::bus_pins_s p, input logic [3:0] pb, input logic [3:0] pa, input int n);
      bus_pins_out = p;
      probe_inputs_out = pb;
      for (int i = 1; i <= n; i++) begin
         target_bus_clock_out = 1'b0;
         // state lines move 50 ns after the fall so the probe sample sees second state
         #50;
         second_bus_state_out = (i == n - 1);
         bus_cycle_end_out = (i == n);
         if (i == n) begin
            probe_inputs_out = pa;
         end
         #50;
         target_bus_clock_out = 1'b1;
         #100;
      end
      target_bus_clock_out = 1'b0;
      #50;
      bus_cycle_end_out = 1'b0;
      bus_pins_out = ~p;
      #50;
   endtask
endmodule

// file: tb.sv
// Purpose: self-checking bench for the bus trace capture block
// Assumes: records are read back through the register port
// Notes: bus clock is unrelated in phase to ref_clk_in
`timescale 1ns/1ps
module tb;
   logic                 ref_clk_in = 1'b0;
   logic                 sys_rst_in = 1'b1;
   logic                 perf_time_over_in = 1'b0;
   logic                 perf_count_over_in = 1'b0;
   logic                 delay_met_in = 1'b0;
   logic [3:0]           reg_addr_in = 4'h0;
   logic [31:0]          reg_wdata_in = 32'h0;
   logic                 reg_wr_in = 1'b0;
   logic                 reg_rd_in = 1'b0;
   logic [31:0]          reg_rdata_out;
   logic                 irq_out;
   logic                 running_out;
   logic                 bclk, t2, cend;
   trace_pkg::bus_pins_s pins, p0, p1;
   logic [3:0]           probe_inputs;
   logic [31:0]          d, s0;
   int                   num_errors = 0;
   int                   samples_checked = 0;
   always #12.5 ref_clk_in = ~ref_clk_in;
   target_bus_model u_tgt (.target_bus_clock_out(bclk), .second_bus_state_out(t2), .bus_cycle_end_out(cend),
                           .bus_pins_out(pins), .probe_inputs_out(probe_inputs));
   bus_trace_capture u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .target_bus_clock_in(bclk),
      .second_bus_state_in(t2), .bus_cycle_end_in(cend), .bus_pins_in(pins), .probe_inputs_in(probe_inputs),
      .perf_time_over_in(perf_time_over_in), .perf_count_over_in(perf_count_over_in), .delay_met_in(delay_met_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .running_out(running_out));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= v;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] x);
      rd(a, d);
      chk(d, x);
   endtask
   function automatic trace_pkg::bus_pins_s mk(input logic [31:0] a, input trace_pkg::cycle_type_e ct, input logic r);
      trace_pkg::bus_pins_s q;
      q = '0;
      q.pc = a ^ 32'h0000F000;
      q.addr = a;
      q.data = ~a;
      q.write = a[2];
      q.area = trace_pkg::MA_RAM;
      q.ctype = ct;
      q.pc_rel = r;
      q.irq = a[11:4];
      q.nmi = a[3];
      q.res = 1'b1;
      q.bus_request_input = 1'b1;
      return q;
   endfunction
   function automatic logic [31:0] info(input trace_pkg::bus_pins_s q, input logic [3:0] pr);
      return {9'h0, pr, q.bus_request_input, q.manual_reset_input, q.res, q.nmi, q.irq, (q.pc_rel ? trace_pkg::CT_PRG : q.ctype), q.area, q.write};
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      #200000;
      num_errors++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rchk(trace_pkg::REG_CTRL, 32'h0);
      rchk(4'hF, 32'h0);
      for (int m = 0; m < 7; m++) begin
         wr(trace_pkg::REG_CTRL, m << 4);
         rchk(trace_pkg::REG_CTRL, m << 4);
      end
      // dma cycles dropped, stamp counts bus clocks, delay point after the first record
      wr(trace_pkg::REG_IMASK, 32'h7);
      wr(trace_pkg::REG_CTRL, 32'hB1);
      p0 = mk(32'h100, trace_pkg::CT_DAT, 1'b0);
      p1 = mk(32'h308, trace_pkg::CT_DAT, 1'b1);
      u_tgt.cycle(p0, 4'hA, 4'h5, 3);
      @(posedge ref_clk_in);
      delay_met_in <= 1'b1;
      @(posedge ref_clk_in);
      delay_met_in <= 1'b0;
      u_tgt.cycle(mk(32'h204, trace_pkg::CT_DMA, 1'b0), 4'h3, 4'h3, 3);
      u_tgt.cycle(p1, 4'hC, 4'h3, 4);
      repeat (6) @(posedge ref_clk_in);
      rchk(trace_pkg::REG_STAT, 32'h21);
      chk({31'h0, irq_out}, 32'h1);
      rchk(trace_pkg::REG_ISTAT, 32'h4);
      rchk(trace_pkg::REG_ISTAT, 32'h0);
      chk({31'h0, irq_out}, 32'h0);
      wr(trace_pkg::REG_RIDX, 32'h0);
      rchk(trace_pkg::REG_R_PC, p0.pc);
      rchk(trace_pkg::REG_R_ADDR, 32'h100);
      rchk(trace_pkg::REG_R_DATA, ~32'h100);
      rchk(trace_pkg::REG_R_INFO, info(p0, 4'hA));
      rchk(trace_pkg::REG_R_CYC, 32'h3);
      rchk(trace_pkg::REG_R_PTR, 32'hFFFFFFFF);
      rd(trace_pkg::REG_R_TS, s0);
      wr(trace_pkg::REG_RIDX, 32'h1);
      rchk(trace_pkg::REG_R_INFO, info(p1, 4'hC));
      rchk(trace_pkg::REG_R_CYC, 32'h4);
      rchk(trace_pkg::REG_R_PTR, 32'h0);
      rd(trace_pkg::REG_R_TS, d);
      chk(d - s0, 32'h7);
      // timeout stop from either limit, dma recorded, interrupt unmasked then masked
      for (int k = 0; k < 2; k++) begin
         wr(trace_pkg::REG_IMASK, k ? 32'h6 : 32'h7);
         wr(trace_pkg::REG_CTRL, 32'h8B);
         u_tgt.cycle(mk(32'h40, trace_pkg::CT_DMA, 1'b0), 4'h0, 4'h0, 3);
         @(posedge ref_clk_in);
         perf_time_over_in <= (k == 0);
         perf_count_over_in <= (k == 1);
         repeat (3) @(posedge ref_clk_in);
         perf_time_over_in <= 1'b0;
         perf_count_over_in <= 1'b0;
         u_tgt.cycle(mk(32'h80, trace_pkg::CT_DAT, 1'b0), 4'h0, 4'h0, 3);
         repeat (6) @(posedge ref_clk_in);
         chk({31'h0, running_out}, 32'h0);
         rchk(trace_pkg::REG_STAT, 32'h1A);
         chk({31'h0, irq_out}, (k == 0));
         rchk(trace_pkg::REG_ISTAT, 32'h1);
      end
      // overflow stop keeps the first sixteen, then wrap-around overwrites slot 0 with quarter-rate stamp
      for (int k = 0; k < 2; k++) begin
         wr(trace_pkg::REG_CTRL, k ? 32'hD1 : 32'h85);
         for (int i = 0; i < 17; i++) begin
            u_tgt.cycle(mk(32'h1000 + 16 * (i + 32 * k), trace_pkg::CT_DAT, 1'b0), 4'h0, 4'h0, 3);
         end
         repeat (6) @(posedge ref_clk_in);
         wr(trace_pkg::REG_RIDX, 32'h0);
         rchk(trace_pkg::REG_R_ADDR, k ? 32'h1300 : 32'h1000);
         if (k == 0) begin
            rchk(trace_pkg::REG_STAT, 32'h106);
            rchk(trace_pkg::REG_ISTAT, 32'h3);
         end else begin
            rchk(trace_pkg::REG_RIDX, 32'h10);
            rchk(trace_pkg::REG_ISTAT, 32'h2);
            // twelve bus clock rises lie between the ends of records 1 and 5
            wr(trace_pkg::REG_RIDX, 32'h1);
            rd(trace_pkg::REG_R_TS, s0);
            wr(trace_pkg::REG_RIDX, 32'h5);
            rd(trace_pkg::REG_R_TS, d);
            chk(d - s0, 32'h3);
         end
      end
      test_done();
   end
endmodule

// file: trace_pkg.sv
// Purpose: constants and carriers for the bus trace capture block
// Assumes: one 40 MHz clock, word-indexed plain register port
// Notes: register indices below are word addresses
package trace_pkg;
   // ****************************************
   // sizes and registers
   // ****************************************
   localparam int DEPTH   = 16;
   localparam int PTR_W   = 4;
   localparam int SEQ_W   = 16;
   localparam int ADDR_W  = 4;
   localparam int MAX_SMP = 3;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_ISTAT  = 4'h2;
   localparam logic [ADDR_W-1:0] REG_IMASK  = 4'h3;
   localparam logic [ADDR_W-1:0] REG_RIDX   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_R_PC   = 4'h5;
   localparam logic [ADDR_W-1:0] REG_R_ADDR = 4'h6;
   localparam logic [ADDR_W-1:0] REG_R_DATA = 4'h7;
   localparam logic [ADDR_W-1:0] REG_R_INFO = 4'h8;
   localparam logic [ADDR_W-1:0] REG_R_CYC  = 4'h9;
   localparam logic [ADDR_W-1:0] REG_R_TS   = 4'hA;
   localparam logic [ADDR_W-1:0] REG_R_PTR  = 4'hB;
   localparam int IRQ_STOP = 0;
   localparam int IRQ_WRAP = 1;
   localparam int IRQ_DLY  = 2;
   // ****************************************
   // time stamp
   // ****************************************
   localparam int CLK_PS   = 25000;
   localparam int TS0_PS   = 20000;
   localparam int TS1_PS   = 1600000;
   localparam int TS2_PS   = 52000000;
   localparam int TS0_CYC  = (TS0_PS + CLK_PS - 1) / CLK_PS;
   localparam int TS1_CYC  = (TS1_PS + CLK_PS - 1) / CLK_PS;
   localparam int TS2_CYC  = (TS2_PS + CLK_PS - 1) / CLK_PS;
   typedef enum logic [2:0] {TS_20NS, TS_1US6, TS_52US, TS_BCLK, TS_BCLK2, TS_BCLK4, TS_BCLK8} ts_mode_e;
   typedef enum logic [2:0] {CT_DMA, CT_DBG, CT_REL, CT_DAT, CT_PRG} cycle_type_e;
   typedef enum logic [2:0] {MA_EXT, MA_ROM, MA_IO, MA_RAM, MA_NON} mem_area_e;
   typedef struct packed {
      logic        start;
      ts_mode_e    ts_mode;
      logic        dma_en;
      logic        ovf_stop_en;
      logic        tmo_stop_en;
      logic        run;
   } ctrl_s;
   localparam ctrl_s CTRL_RST = '{start: 1'b0, ts_mode: TS_20NS, dma_en: 1'b0,
                                  ovf_stop_en: 1'b0, tmo_stop_en: 1'b0, run: 1'b0};
   typedef struct packed {
      logic [31:0] pc;
      logic [31:0] addr;
      logic [31:0] data;
      logic        write;
      mem_area_e   area;
      cycle_type_e ctype;
      logic        pc_rel;
      logic [7:0]  irq;
      logic        nmi;
      logic        res;
      logic        manual_reset_input;
      logic        bus_request_input;
   } bus_pins_s;
   typedef struct packed {
      bus_pins_s          bus;
      logic [3:0]         probe;
      logic [7:0]         cycles;
      logic [31:0]        stamp;
      logic [SEQ_W-1:0]   seq;
   } record_s;
endpackage
